//--- verilog/cxc_pkg.sv
// Constants and types for the context exchange control block
package cxc_pkg;
  // Operating register files and package geometry
  localparam int A_N       = 8;
  localparam int A_W       = 24;
  localparam int S_N       = 8;
  localparam int W_W       = 64;
  localparam int PKG_WORDS = 16;
  localparam int XA_W      = 8;
  localparam int XADDR_W   = 12;
  // Program and instruction fetch widths
  localparam int P_W       = 22;
  localparam int WA_W      = 20;
  localparam int PAR_W     = 16;
  localparam int BUF_N     = 4;
  localparam int BUF_LEN   = 128;
  localparam int IDX_W     = 7;
  localparam int SLOT_W    = 2;
  localparam int BLK_W     = P_W - IDX_W;
  // Memory error report and processor number widths
  localparam int PN_W      = 4;
  localparam int SYN_W     = 8;
  localparam int RM_W      = 2;
  localparam int LOC_W     = 12;
  // Interrupt flag word bits
  localparam int F_ICP = 0;
  localparam int F_DL  = 1;
  localparam int F_PCI = 2;
  localparam int F_MCU = 3;
  localparam int F_FPE = 4;
  localparam int F_ORE = 5;
  localparam int F_PRE = 6;
  localparam int F_ME  = 7;
  localparam int F_IOI = 8;
  localparam int F_EEX = 9;
  localparam int F_NEX = 10;
  localparam int F_N   = 11;
  // Mode word bits
  localparam int M_WS  = 0;
  localparam int M_FPS = 1;
  localparam int M_BDM = 2;
  localparam int M_SEI = 3;
  localparam int M_IMM = 4;
  localparam int M_IOR = 5;
  localparam int M_ICM = 6;
  localparam int M_IFP = 7;
  localparam int M_IUM = 8;
  localparam int M_MM  = 9;
  localparam int M_N   = 10;
  // Field positions inside package words 0 to 3
  localparam int P_LSB   = 24;
  localparam int RM_LSB  = 46;
  localparam int SYN_LSB = 48;
  localparam int ET_LSB  = 56;
  localparam int IBA_LSB = 24;
  localparam int LOC_LSB = 44;
  localparam int ILA_LSB = 24;
  localparam int XA_LSB  = 44;
  localparam int PN_LSB  = 52;
  localparam int F_LSB   = 24;
  localparam int M_LSB   = 35;
  localparam int VNU_BIT = 45;
  // Register map on the APB side
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_XA   = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0c;
  localparam logic [7:0] REG_PC   = 8'h10;
  localparam int CTRL_XREQ = 0;
  typedef enum logic [1:0] {X_RUN, X_DRAIN, X_READ, X_WRITE} cxc_state_e;
endpackage

//--- verilog/cxc_top.sv
// Context exchange control: issue stop, package swap, fetch bounds
`timescale 1ns/1ps
`default_nettype none
module cxc_top
  import cxc_pkg::*;
#(
  parameter logic [PN_W-1:0] CPU_NUM = 4'h0
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Deadstart pin
  input  wire logic                   deadstart,
  // Central memory port for the swap
  output logic                        memReq,
  output logic                        memWe,
  output logic      [XADDR_W-1:0]     memAddr,
  output logic      [W_W-1:0]         memWdata,
  input  wire logic                   memAck,
  input  wire logic [W_W-1:0]         memRdata,
  input  wire logic                   memBusy,
  input  wire logic                   unitBusy,
  // Instruction fetch
  output logic                        fetchReq,
  output logic      [WA_W-1:0]        fetchAddr,
  input  wire logic                   fillValid,
  input  wire logic [IDX_W-1:0]       fillIdx,
  input  wire logic [PAR_W-1:0]       fillParcel,
  input  wire logic                   fillDone,
  // Issue
  output logic                        issueEn,
  output logic      [PAR_W-1:0]       nipParcel,
  output logic      [PAR_W-1:0]       cipParcel,
  output logic      [PAR_W-1:0]       lipParcel,
  input  wire logic                   issued,
  input  wire logic                   twoParcel,
  input  wire logic                   branch,
  input  wire logic [P_W-1:0]         branchTarget,
  input  wire logic                   tsHold,
  input  wire logic                   vecIssue,
  // Operating register writes and contents
  input  wire logic                   aWe,
  input  wire logic [2:0]             aIdx,
  input  wire logic [A_W-1:0]         aData,
  input  wire logic                   sWe,
  input  wire logic [2:0]             sIdx,
  input  wire logic [W_W-1:0]         sData,
  output logic      [A_N*A_W-1:0]     aRegs,
  output logic      [S_N*W_W-1:0]     sRegs,
  // Event sources, one-cycle pulses
  input  wire logic                   floatErr,
  input  wire logic                   opRangeErr,
  input  wire logic                   corrErr,
  input  wire logic                   uncorrErr,
  input  wire logic                   multiBitErr,
  input  wire logic [SYN_W-1:0]       errSyndrome,
  input  wire logic [RM_W-1:0]        errReadMode,
  input  wire logic [LOC_W-1:0]       errLocation,
  input  wire logic                   interCpuIrq,
  input  wire logic                   deadlockIrq,
  input  wire logic                   pclkIrq,
  input  wire logic                   maintIrq,
  input  wire logic                   ioIrq,
  input  wire logic                   errorExit,
  input  wire logic                   normalExit,
  // Mode outputs
  output logic                        blockBidir,
  output logic                        ioPreferred
);

  typedef struct packed {
    cxc_state_e                         fsm;
    logic [3:0]                         word;
    logic [XA_W-1:0]                    base;
    logic                               dsS1;
    logic                               dsS2;
    logic                               dsPrev;
    logic                               dsPend;
    logic                               volReq;
    logic [A_N-1:0][A_W-1:0]            a;
    logic [S_N-1:0][W_W-1:0]            s;
    logic [P_W-1:0]                     p;
    logic [P_W-1:0]                     cipAddr;
    logic                               cipValid;
    logic [PAR_W-1:0]                   next_parcel_register;
    logic [PAR_W-1:0]                   current_parcel_register;
    logic [PAR_W-1:0]                   lower_parcel_register;
    logic [WA_W-1:0]                    instruction_base_bound;
    logic [WA_W-1:0]                    instruction_limit_bound;
    logic [XA_W-1:0]                    xa;
    logic [F_N-1:0]                     flags;
    logic [M_N-1:0]                     mode;
    logic                               vecUsed;
    logic [1:0]                         errType;
    logic [SYN_W-1:0]                   syn;
    logic [RM_W-1:0]                    rmode;
    logic [LOC_W-1:0]                   loc;
    logic [BUF_N-1:0][BLK_W-1:0]        tag;
    logic [BUF_N-1:0]                   tagV;
    logic [SLOT_W-1:0]                  victim;
    logic [BUF_N*BUF_LEN-1:0][PAR_W-1:0] ibuf;
    logic [W_W-1:0]                     wdata;
    logic [31:0]                        rdata;
  } cxc_regs_s;

  cxc_regs_s st;
  cxc_regs_s next_st;
  logic      rstS1;
  logic      rstN;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstS1 <= 1'b0;
      rstN  <= 1'b0;
    end else begin
      rstS1 <= 1'b1;
      rstN  <= rstS1;
    end
  end

  // Buffer lookup: hit flag and slot for a parcel address
  function automatic logic [SLOT_W:0] bufFind(input cxc_regs_s r,
                                              input logic [P_W-1:0] ad);
    logic [SLOT_W:0] res;
    res = '0;
    for (int i = 0; i < BUF_N; i++) begin
      if (r.tagV[i] && r.tag[i] == ad[P_W-1:IDX_W]) begin
        res = {1'b1, SLOT_W'(i)};
      end
    end
    return res;
  endfunction

  logic [SLOT_W:0]  find0;
  logic [SLOT_W:0]  find1;
  logic [P_W-1:0]   pNext;
  logic [P_W-1:0]   missAddr;
  logic [P_W-1:0]   storedP;
  logic             needFill;
  logic             inRange;
  logic             trig;
  logic             dsEdge;
  logic [F_N-1:0]   ev;
  logic [F_N-1:0]   allow;
  logic [W_W-1:0]   outWord;
  logic             apbWr;
  logic             apbHit;

  assign pNext    = P_W'(st.p + 1'b1);
  assign find0    = bufFind(st, st.p);
  assign find1    = bufFind(st, pNext);
  assign needFill = !st.cipValid && !(find0[SLOT_W] && find1[SLOT_W]);
  assign missAddr = find0[SLOT_W] ? pNext : st.p;
  assign fetchAddr = WA_W'({missAddr[P_W-1:IDX_W], {IDX_W{1'b0}}} >> 2);
  assign inRange  = fetchAddr >= st.instruction_base_bound && fetchAddr < st.instruction_limit_bound;
  assign storedP  = st.cipValid ? st.cipAddr : st.p;
  assign dsEdge   = st.dsS2 && !st.dsPrev;
  assign trig     = (|st.flags) || st.volReq || st.dsPend;

  // Outputs
  assign issueEn   = st.fsm == X_RUN && !trig && st.cipValid;
  assign fetchReq  = st.fsm == X_RUN && !trig && needFill && inRange;
  assign memReq    = st.fsm == X_READ || st.fsm == X_WRITE;
  assign memWe     = st.fsm == X_WRITE;
  assign memAddr   = {st.base, st.word};
  assign memWdata  = st.wdata;
  assign nipParcel = st.next_parcel_register;
  assign cipParcel = st.current_parcel_register;
  assign lipParcel = st.lower_parcel_register;
  assign aRegs     = st.a;
  assign sRegs     = st.s;
  assign blockBidir  = st.mode[M_BDM];
  assign ioPreferred = st.mode[M_SEI];
  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign apbHit  = paddr == REG_CTRL || paddr == REG_STAT ||
                   paddr == REG_XA || paddr == REG_MODE || paddr == REG_PC;
  assign pslverr = psel && penable && !apbHit;
  assign apbWr   = psel && penable && pwrite && paddr == REG_CTRL;

  // Interrupt masking by mode
  always_comb begin
    allow = '1;
    if (st.mode[M_MM] && st.mode[M_IMM]) begin
      allow[F_PCI] = 1'b0;
      allow[F_MCU] = 1'b0;
      allow[F_IOI] = 1'b0;
      allow[F_NEX] = 1'b0;
      allow[F_ICP] = 1'b0;
    end else if (st.mode[M_MM]) begin
      allow = '0;
      allow[F_ME]  = 1'b1;
      allow[F_NEX] = 1'b1;
      allow[F_EEX] = 1'b1;
    end
    ev        = '0;
    ev[F_ICP] = interCpuIrq;
    ev[F_DL]  = deadlockIrq;
    ev[F_PCI] = pclkIrq;
    ev[F_MCU] = maintIrq;
    ev[F_FPE] = floatErr && st.mode[M_IFP];
    ev[F_ORE] = opRangeErr && st.mode[M_IOR];
    ev[F_PRE] = st.fsm == X_RUN && needFill && !inRange;
    ev[F_ME]  = (corrErr && st.mode[M_ICM]) ||
                (uncorrErr && st.mode[M_IUM]);
    ev[F_IOI] = ioIrq;
    ev[F_EEX] = errorExit;
    ev[F_NEX] = normalExit;
  end

  // Outgoing package word from the old context
  always_comb begin
    outWord = '0;
    if (st.word[3]) begin
      outWord = st.s[st.word[2:0]];
    end else begin
      outWord[A_W-1:0] = st.a[st.word[2:0]];
      case (st.word[2:0])
        3'h0: begin
          outWord[P_LSB +: P_W]     = storedP;
          outWord[RM_LSB +: RM_W]   = st.rmode;
          outWord[SYN_LSB +: SYN_W] = st.syn;
          outWord[ET_LSB +: 2]      = st.errType;
        end
        3'h1: begin
          outWord[IBA_LSB +: WA_W]  = st.instruction_base_bound;
          outWord[LOC_LSB +: LOC_W] = st.loc;
        end
        3'h2: begin
          outWord[ILA_LSB +: WA_W] = st.instruction_limit_bound;
          outWord[XA_LSB +: XA_W]  = st.xa;
          outWord[PN_LSB +: PN_W]  = CPU_NUM;
        end
        3'h3: begin
          outWord[F_LSB +: F_N]   = st.flags;
          outWord[M_LSB +: M_N]   = st.mode;
          outWord[M_LSB + M_WS]   = tsHold && st.cipValid;
          outWord[VNU_BIT]        = !st.vecUsed;
        end
        default: outWord = outWord;
      endcase
    end
  end

  always_comb begin
    next_st        = st;
    next_st.dsS1   = deadstart;
    next_st.dsS2   = st.dsS1;
    next_st.dsPrev = st.dsS2;
    // Set wins over clear at exchange start
    next_st.dsPend = (st.dsPend && st.fsm != X_DRAIN) || dsEdge;
    next_st.volReq = (st.volReq && st.fsm != X_DRAIN) ||
                     (apbWr && pwdata[CTRL_XREQ]);
    if (psel && !penable) begin
      case (paddr)
        REG_STAT: next_st.rdata = 32'({st.flags, st.cipValid, st.fsm});
        REG_XA:   next_st.rdata = 32'(st.xa);
        REG_MODE: next_st.rdata = 32'({!st.vecUsed, st.mode});
        REG_PC:   next_st.rdata = 32'(storedP);
        default:  next_st.rdata = 32'h00000000;
      endcase
    end
    if (aWe) begin
      next_st.a[aIdx] = aData;
    end
    if (sWe) begin
      next_st.s[sIdx] = sData;
    end
    // Buffer fill from memory, independent of the swap
    if (fillValid) begin
      next_st.ibuf[{st.victim, fillIdx}] = fillParcel;
      next_st.tagV[st.victim] = 1'b0;
    end
    if (fillDone) begin
      next_st.tag[st.victim]  = missAddr[P_W-1:IDX_W];
      next_st.tagV[st.victim] = 1'b1;
      next_st.victim          = SLOT_W'(st.victim + 1'b1);
    end
    case (st.fsm)
      X_RUN: begin
        next_st.flags = st.flags | (ev & allow);
        next_st.mode[M_FPS] = st.mode[M_FPS] || floatErr;
        next_st.vecUsed = st.vecUsed || vecIssue;
        if (multiBitErr) begin
          next_st.errType[0] = 1'b1;
        end
        if (ev[F_ME] && allow[F_ME]) begin
          next_st.errType = {uncorrErr, corrErr || multiBitErr};
          next_st.syn     = errSyndrome;
          next_st.rmode   = errReadMode;
          next_st.loc     = errLocation;
        end
        if (trig) begin
          next_st.fsm  = X_DRAIN;
          next_st.base = st.dsPend ? '0 : st.xa;
        end else if (branch) begin
          next_st.p        = branchTarget;
          next_st.cipValid = 1'b0;
        end else if (issued && st.cipValid) begin
          next_st.cipValid = 1'b0;
          if (twoParcel) begin
            next_st.p = pNext;
          end
        end else if (!needFill) begin
          if (!st.cipValid) begin
            next_st.current_parcel_register = st.ibuf[{find0[SLOT_W-1:0], st.p[IDX_W-1:0]}];
            next_st.lower_parcel_register = st.ibuf[{find1[SLOT_W-1:0], pNext[IDX_W-1:0]}];
            next_st.next_parcel_register = next_st.lower_parcel_register;
            next_st.cipAddr  = st.p;
            next_st.cipValid = 1'b1;
            next_st.p        = pNext;
          end
        end
      end
      X_DRAIN: begin
        // Outstanding bank and unit work must finish first
        if (!memBusy && !unitBusy) begin
          next_st.fsm  = X_READ;
          next_st.word = 4'h0;
        end
      end
      X_READ: begin
        if (memAck) begin
          next_st.wdata = outWord;
          next_st.fsm   = X_WRITE;
          if (st.word[3]) begin
            next_st.s[st.word[2:0]] = memRdata;
          end else begin
            next_st.a[st.word[2:0]] = memRdata[A_W-1:0];
            case (st.word[2:0])
              3'h0: next_st.p   = memRdata[P_LSB +: P_W];
              3'h1: next_st.instruction_base_bound = memRdata[IBA_LSB +: WA_W];
              3'h2: next_st.xa  = memRdata[XA_LSB +: XA_W];
              3'h3: begin
                next_st.flags = memRdata[F_LSB +: F_N];
                next_st.mode  = memRdata[M_LSB +: M_N];
              end
              default: next_st.p = next_st.p;
            endcase
            if (st.word[2:0] == 3'h2) begin
              next_st.instruction_limit_bound = memRdata[ILA_LSB +: WA_W];
            end
          end
        end
      end
      X_WRITE: begin
        if (memAck) begin
          next_st.word = 4'(st.word + 1'b1);
          next_st.fsm  = X_READ;
          if (st.word == 4'(PKG_WORDS - 1)) begin
            // New execution interval
            next_st.fsm      = X_RUN;
            next_st.cipValid = 1'b0;
            next_st.vecUsed  = 1'b0;
            next_st.errType  = '0;
          end
        end
      end
      default: next_st.fsm = X_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  AST_NO_ISSUE: assert property (st.fsm != X_RUN |-> !issueEn)
    else $error("issue enabled during exchange");
  AST_DRAIN_HOLD: assert property (
    st.fsm == X_DRAIN && (memBusy || unitBusy) |=> st.fsm == X_DRAIN)
    else $error("swap started before drain");
  AST_READ_FIRST: assert property (
    st.fsm == X_READ && memAck |=> memWe && $stable(memAddr))
    else $error("write did not follow read of same word");
  AST_ADDR: assert property (st.fsm == X_WRITE && memAck &&
    st.word != 4'hf |=> memAddr == XADDR_W'($past(memAddr) + 12'h1))
    else $error("package words not consecutive");
  AST_PN: assert property (memWe && st.word == 4'h2 |->
    memWdata[PN_LSB +: PN_W] == CPU_NUM)
    else $error("processor number wrong");
  AST_BOUND: assert property (fetchReq |->
    fetchAddr >= st.instruction_base_bound && fetchAddr < st.instruction_limit_bound)
    else $error("fetch outside bounds");
  AST_FPS: assert property (st.fsm == X_RUN && floatErr |=>
    st.mode[M_FPS])
    else $error("float status not set");
  AST_FLAG_SWAP: assert property (st.fsm == X_RUN && |st.flags |=>
    st.fsm == X_DRAIN ##1 !issueEn)
    else $error("set flag did not request swap");
  AST_SUP_IO: assert property (st.fsm == X_RUN && st.mode[M_MM] &&
    !st.mode[M_IMM] && !st.flags[F_IOI] |=> !st.flags[F_IOI])
    else $error("I/O interrupt not inhibited");
  AST_PC_STEP: assert property (st.fsm == X_RUN && !trig &&
    !branch && !st.cipValid && !needFill |=> st.p == $past(pNext))
    else $error("program counter did not advance");

  CV_SWAP: cover property (st.fsm == X_WRITE && memAck && st.word == 4'hf);
  CV_VOL: cover property (apbWr && pwdata[CTRL_XREQ] ##[1:40] memReq);
  CV_FILL: cover property (fetchReq ##[1:300] fillDone);
  CV_ISSUE: cover property (issueEn && issued && twoParcel);

endmodule
`default_nettype wire

//--- testbench/cxc_mem_model.sv
// Central memory model holding stored context packages
`timescale 1ns/1ps
`default_nettype none
module cxc_mem_model
  import cxc_pkg::*;
(
  // Clock
  input  wire logic               mclk,
  // Swap port
  input  wire logic               memReq,
  input  wire logic               memWe,
  input  wire logic [XADDR_W-1:0] memAddr,
  input  wire logic [W_W-1:0]     memWdata,
  output logic                    memAck,
  output logic      [W_W-1:0]     memRdata,
  // Extra wait cycles before each answer
  input  wire logic [3:0]         slow
);
  logic [W_W-1:0]     mem [0:4095];
  logic [3:0]         waitCnt = 4'h0;
  logic               rdSeen = 1'b0;
  logic [XADDR_W-1:0] rdAddr = '0;
  int                 writes = 0;
  logic               orderBad = 1'b0;
  initial memAck = 1'b0;
  initial memRdata = '0;
  always @(posedge mclk) begin
    memAck <= 1'b0;
    // Idle data toggles so a stale word never passes for a fresh one
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt < slow) begin
        waitCnt <= waitCnt + 4'h1;
      end else begin
        waitCnt <= 4'h0;
        memAck  <= 1'b1;
        if (memWe) begin
          mem[memAddr] <= memWdata;
          writes       <= writes + 1;
          orderBad     <= orderBad | !(rdSeen && rdAddr == memAddr);
          rdSeen       <= 1'b0;
        end else begin
          memRdata <= mem[memAddr];
          rdSeen   <= 1'b1;
          rdAddr   <= memAddr;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/cxc_tb_top.sv
// Self-checking bench for the context exchange control block
`timescale 1ns/1ps
`default_nettype none
module cxc_tb_top
  import cxc_pkg::*;
;
  logic               mclk = 1'b0, arst_n = 1'b0, deadstart = 1'b0;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = '0;
  logic [31:0]        pwdata = '0;
  logic               memBusy = 1'b0, unitBusy = 1'b0;
  logic               fillValid = 1'b0, fillDone = 1'b0;
  logic [IDX_W-1:0]   fillIdx = '0;
  logic [PAR_W-1:0]   fillParcel = '0;
  logic               issued = 1'b0, twoParcel = 1'b0, branch = 1'b0;
  logic [P_W-1:0]     branchTarget = '0;
  logic               tsHold = 1'b0, vecIssue = 1'b0, aWe = 1'b0, sWe = 1'b0;
  logic [2:0]         aIdx = '0, sIdx = '0;
  logic [A_W-1:0]     aData = '0;
  logic [W_W-1:0]     sData = '0;
  logic               floatErr = 1'b0, opRangeErr = 1'b0, corrErr = 1'b0;
  logic               uncorrErr = 1'b0, multiBitErr = 1'b0, ioIrq = 1'b0;
  logic               interCpuIrq = 1'b0, deadlockIrq = 1'b0, pclkIrq = 1'b0;
  logic               maintIrq = 1'b0, errorExit = 1'b0, normalExit = 1'b0;
  logic [SYN_W-1:0]   errSyndrome = '0;
  logic [RM_W-1:0]    errReadMode = '0;
  logic [LOC_W-1:0]   errLocation = '0;
  logic [3:0]         slow = 4'h0;
  logic [31:0]        prdata;
  logic               pready, pslverr, memReq, memWe, memAck;
  logic [XADDR_W-1:0] memAddr;
  logic [W_W-1:0]     memWdata, memRdata;
  logic               fetchReq, issueEn, blockBidir, ioPreferred;
  logic [WA_W-1:0]    fetchAddr;
  logic [PAR_W-1:0]   nipParcel, cipParcel, lipParcel;
  logic [A_N*A_W-1:0] aRegs;
  logic [S_N*W_W-1:0] sRegs;
  int                 numErrors = 0, cmpCount = 0, cycles = 0;
  logic [31:0]        rd;
  logic               er;
  // Rows: address, mask, expected read data, expected error
  logic [72:0]        rows [6] = '{
    {REG_XA,   32'hff,       32'h1, 1'b0},
    {REG_CTRL, 32'hffffffff, 32'h0, 1'b0},
    {REG_STAT, 32'h3ffb,     32'h0, 1'b0},
    {REG_MODE, 32'h3ff,      32'h0, 1'b0},
    {REG_PC,   32'h3fffff,   32'h100, 1'b0},
    {8'h14,    32'hffffffff, 32'h0, 1'b1}};

  cxc_top #(.CPU_NUM(4'h5)) u_cxc_top (.*);
  cxc_mem_model u_cxc_mem_model (.*);

  always #20 mclk = ~mclk;

  task automatic completeRun();
    $display("compares %0d errors %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Generous ceiling; five swaps and one fill need well under it
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      numErrors++;
      completeRun();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitWrites(input int n);
    while (u_cxc_mem_model.writes < n) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask

  // Package: A and S words count up, P 0x100, limit word 0x1000
  task automatic pkg(input int b, input logic [7:0] xa);
    for (int k = 0; k < PKG_WORDS; k++)
      u_cxc_mem_model.mem[b+k] = 64'(b + k + 1);
    u_cxc_mem_model.mem[b] = {18'h0, 22'h100, 24'(b + 1)};
    u_cxc_mem_model.mem[b+2] = {8'h0, 4'hf, xa, 20'h01000, 24'(b + 3)};
  endtask

  initial begin
    pkg(0, 8'h01);
    pkg(16, 8'h02);
    pkg(32, 8'h00);
    // Third package turns on block overlap and I/O preference
    u_cxc_mem_model.mem[35][M_LSB+M_BDM] = 1'b1;
    u_cxc_mem_model.mem[35][M_LSB+M_SEI] = 1'b1;
    repeat (2) @(posedge mclk);
    check(64'({memReq, fetchReq, issueEn, pready}), 64'h1);
    arst_n <= 1'b1;
    waitWrites(16);
    check(64'(aRegs[23:0]), 64'h1);
    check(64'(u_cxc_mem_model.mem[2][55:52]), 64'h5);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][72:65], 32'h0);
      check(64'(rd & rows[i][64:33]), 64'(rows[i][32:1]));
      check(64'(er), 64'(rows[i][0]));
    end
    while (!fetchReq) @(posedge mclk);
    check(64'(fetchAddr), 64'h40);
    for (int i = 0; i < 128; i++) begin
      @(posedge mclk);
      fillValid  <= 1'b1;
      fillIdx    <= 7'(i);
      fillParcel <= 16'h1000 + 16'(i);
    end
    @(posedge mclk);
    fillValid <= 1'b0;
    fillDone  <= 1'b1;
    @(posedge mclk);
    fillDone  <= 1'b0;
    while (!issueEn) @(posedge mclk);
    check(64'(cipParcel), 64'h1000);
    check(64'(lipParcel), 64'h1001);
    check(64'(nipParcel), 64'h1001);
    issued    <= 1'b1;
    twoParcel <= 1'b1;
    @(posedge mclk);
    issued    <= 1'b0;
    twoParcel <= 1'b0;
    repeat (2) @(posedge mclk);
    while (!issueEn) @(posedge mclk);
    check(64'(cipParcel), 64'h1002);
    floatErr <= 1'b1;
    @(posedge mclk);
    floatErr <= 1'b0;
    apb(1'b0, REG_MODE, 32'h0);
    check(64'(rd[M_FPS]), 64'h1);
    apb(1'b0, REG_STAT, 32'h0);
    check(64'(rd[1:0]), 64'h0);
    // Branch to the limit word itself; slow memory for this swap
    slow         <= 4'h2;
    tsHold       <= 1'b1;
    branch       <= 1'b1;
    branchTarget <= 22'h4000;
    @(posedge mclk);
    branch <= 1'b0;
    waitWrites(32);
    slow   <= 4'h0;
    check(64'(u_cxc_mem_model.mem[19][F_LSB+F_PRE]), 64'h1);
    check(64'(u_cxc_mem_model.mem[19][F_LSB+F_FPE]), 64'h0);
    // Branch emptied the parcel register, so nothing was holding there
    check(64'(u_cxc_mem_model.mem[19][M_LSB+M_WS]), 64'h0);
    check(64'(u_cxc_mem_model.mem[19][M_LSB+M_FPS]), 64'h1);
    check(64'(u_cxc_mem_model.mem[19][VNU_BIT]), 64'h1);
    check(64'(u_cxc_mem_model.mem[16][45:24]), 64'h4000);
    check(64'(u_cxc_mem_model.mem[16][23:0]), 64'h1);
    check(sRegs[63:0], 64'h19);
    aWe   <= 1'b1;
    aData <= 24'habcdef;
    vecIssue <= 1'b1;
    sWe   <= 1'b1;
    sData <= 64'hfeedface01234567;
    @(posedge mclk);
    aWe      <= 1'b0;
    sWe      <= 1'b0;
    vecIssue <= 1'b0;
    memBusy  <= 1'b1;
    unitBusy <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    apb(1'b0, REG_STAT, 32'h0);
    check(64'(rd[1:0]), 64'h1);
    // Events outside the run state must be dropped
    {opRangeErr, corrErr, uncorrErr, multiBitErr, interCpuIrq, deadlockIrq,
     pclkIrq, maintIrq, ioIrq, errorExit, normalExit, errSyndrome,
     errReadMode, errLocation} <= '1;
    @(posedge mclk);
    {opRangeErr, corrErr, uncorrErr, multiBitErr, interCpuIrq, deadlockIrq,
     pclkIrq, maintIrq, ioIrq, errorExit, normalExit, errSyndrome,
     errReadMode, errLocation} <= '0;
    memBusy  <= 1'b0;
    unitBusy <= 1'b0;
    waitWrites(48);
    tsHold <= 1'b0;
    check(64'(u_cxc_mem_model.mem[35][M_LSB+M_WS]), 64'h1);
    check(64'(u_cxc_mem_model.mem[35][VNU_BIT]), 64'h0);
    check(64'(u_cxc_mem_model.mem[32][45:24]), 64'h100);
    check(64'({blockBidir, ioPreferred}), 64'h3);
    check(64'(u_cxc_mem_model.mem[32][23:0]), 64'habcdef);
    check(u_cxc_mem_model.mem[40], 64'hfeedface01234567);
    check(64'(u_cxc_mem_model.mem[34][51:44]), 64'h2);
    check(64'(u_cxc_mem_model.mem[34][55:52]), 64'h5);
    repeat (20) @(posedge mclk);
    check(64'(u_cxc_mem_model.writes), 64'd48);
    pkg(0, 8'h00);
    // Supervisor with uncorrectable errors enabled after deadstart
    u_cxc_mem_model.mem[3][M_LSB+M_MM]  = 1'b1;
    u_cxc_mem_model.mem[3][M_LSB+M_IUM] = 1'b1;
    deadstart <= 1'b1;
    repeat (3) @(posedge mclk);
    deadstart <= 1'b0;
    waitWrites(64);
    check(64'(u_cxc_mem_model.mem[0][23:0]), 64'h21);
    check(64'(u_cxc_mem_model.writes), 64'd64);
    check(64'(u_cxc_mem_model.orderBad), 64'h0);
    // Multi-bit uncorrectable error passes, I/O is held off
    {uncorrErr, multiBitErr, ioIrq} <= 3'h7;
    errSyndrome <= 8'h5a;
    errReadMode <= 2'h2;
    errLocation <= 12'h3c5;
    @(posedge mclk);
    {uncorrErr, multiBitErr, ioIrq} <= 3'h0;
    waitWrites(80);
    check(64'(u_cxc_mem_model.mem[0][57:46]), 64'hd6a);
    check(64'(u_cxc_mem_model.mem[1][55:44]), 64'h3c5);
    check(64'(u_cxc_mem_model.mem[3][F_LSB+F_ME]), 64'h1);
    check(64'(u_cxc_mem_model.mem[3][F_LSB+F_IOI]), 64'h0);
    completeRun();
  end
endmodule
`default_nettype wire
